// >>> logic/pde_port_ctrl.sv
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
// What this block does
// - spi enable gives pin d2 to mosi
// - spi enable gives pin d1 to miso
// - spi owns drive; direction still picks readback
// - d0 slave select only when spi slave
// - direction bit ignored for slave select pin drive while spi slave
// - port d direction one drives, reset clears
// - port d read: latch if output, else pin
// - data writes always update latch
// - pullup enable connects pullup on inputs
// - output direction removes pullup automatically
// - serial enable gives pin e1 to receive
// - serial enable gives pin e0 to transmit
// - serial owns drive; direction still picks readback
// - port e direction one drives, reset clears
// - port e read: latch if output, else pin
// - spi enable gives pin d3 to clock
// - timer level select claims pins d4-d6
module pde_port_ctrl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // spi module controls and signals
  input wire logic spi_module_enable,
  input wire logic spi_master_select,
  input wire logic spi_mosi_out,
  input wire logic spi_mosi_oe,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe,
  input wire logic spi_sck_out,
  input wire logic spi_sck_oe,
  output logic spi_mosi_in,
  output logic spi_miso_in,
  output logic spi_sck_in,
  output logic spi_select_in,
  // timer channel controls and signals (d4, d5, d6)
  input wire logic [2:0] edge_level_select_high,
  input wire logic [2:0] edge_level_select_low,
  input wire logic [2:0] tmr_ch_out,
  input wire logic [2:0] tmr_ch_oe,
  output logic [2:0] tmr_ch_in,
  // serial interface controls and signals
  input wire logic serial_iface_enable,
  input wire logic sci_txd_out,
  output logic sci_rxd_in,
  // port d pins
  input wire logic [6:0] pd_pin_in,
  output logic [6:0] pd_pin_out,
  output logic [6:0] pd_pin_oe,
  output logic [6:0] pd_pullup_on,
  // port e pins
  input wire logic [1:0] pe_pin_in,
  output logic [1:0] pe_pin_out,
  output logic [1:0] pe_pin_oe
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [6:0] pd_lat_reg; // port_d_data_latch
  logic [6:0] pd_dir_reg; // port_d_direction
  logic [6:0] pd_pue_reg; // port_d_pullup_enable
  logic [1:0] pe_lat_reg; // port_e_data_latch
  logic [1:0] pe_dir_reg; // port_e_direction
  logic [7:0] rdata_next;
  // synchronised pin levels
  logic [6:0] pd_sync;
  logic [1:0] pe_sync;
  // ownership decode
  wire spi_on = spi_module_enable;
  wire spi_sel_on = spi_module_enable & ~spi_master_select;
  wire sci_on = serial_iface_enable;
  wire [2:0] tmr_on = edge_level_select_high | edge_level_select_low;
  // per-pin peripheral ownership and drive
  logic [6:0] pd_own;
  logic [6:0] pd_per_out;
  logic [6:0] pd_per_oe;
  logic [1:0] pe_own;
  logic [1:0] pe_per_out;
  logic [1:0] pe_per_oe;
  // address decode
  wire hit_pd_data = reg_addr == pde_pkg::ADDR_PD_DATA;
  wire hit_pd_dir = reg_addr == pde_pkg::ADDR_PD_DIR;
  wire hit_pd_pue = reg_addr == pde_pkg::ADDR_PD_PUE;
  wire hit_pe_data = reg_addr == pde_pkg::ADDR_PE_DATA;
  wire hit_pe_dir = reg_addr == pde_pkg::ADDR_PE_DIR;
  wire hit_route = reg_addr == pde_pkg::ADDR_ROUTE;

  // ----------------------------------------------------------------
  // pin input synchronisers (pins are asynchronous to clk_sys)
  // ----------------------------------------------------------------
  pde_sync #(.W(pde_pkg::PD_W), .INIT(7'h00)) u_sync_d (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in(pd_pin_in),
    .sync_out(pd_sync)
  );

  pde_sync #(.W(pde_pkg::PE_W), .INIT(2'h0)) u_sync_e (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in(pe_pin_in),
    .sync_out(pe_sync)
  );

  // ----------------------------------------------------------------
  // port d ownership: spi on d0..d3, timers on d4..d6
  // ----------------------------------------------------------------
  // slave select is an input only; the spi never drives it
  assign pd_own[pde_pkg::PD_SEL] = spi_sel_on;
  assign pd_per_out[pde_pkg::PD_SEL] = 1'b0;
  assign pd_per_oe[pde_pkg::PD_SEL] = 1'b0;
  assign pd_own[pde_pkg::PD_MISO] = spi_on;
  assign pd_per_out[pde_pkg::PD_MISO] = spi_miso_out;
  assign pd_per_oe[pde_pkg::PD_MISO] = spi_miso_oe;
  assign pd_own[pde_pkg::PD_MOSI] = spi_on;
  assign pd_per_out[pde_pkg::PD_MOSI] = spi_mosi_out;
  assign pd_per_oe[pde_pkg::PD_MOSI] = spi_mosi_oe;
  assign pd_own[pde_pkg::PD_SCK] = spi_on;
  assign pd_per_out[pde_pkg::PD_SCK] = spi_sck_out;
  assign pd_per_oe[pde_pkg::PD_SCK] = spi_sck_oe;

  genvar t;
  generate
    for (t = 0; t < pde_pkg::TMR_CH; t++)
    begin : g_tmr
      // timer channel takes its pin while either of its own level select bits is set
      assign pd_own[pde_pkg::PD_TMR0 + t] = tmr_on[t];
      assign pd_per_out[pde_pkg::PD_TMR0 + t] = tmr_ch_out[t];
      assign pd_per_oe[pde_pkg::PD_TMR0 + t] = tmr_ch_oe[t];
      assign tmr_ch_in[t] = pd_sync[pde_pkg::PD_TMR0 + t];
    end
  endgenerate

  // peripheral inputs see the clean pin level
  assign spi_select_in = spi_sel_on ? pd_sync[pde_pkg::PD_SEL] : 1'b1;
  assign spi_miso_in = pd_sync[pde_pkg::PD_MISO];
  assign spi_mosi_in = pd_sync[pde_pkg::PD_MOSI];
  assign spi_sck_in = pd_sync[pde_pkg::PD_SCK];

  // ----------------------------------------------------------------
  // port e ownership: serial interface on both pins
  // ----------------------------------------------------------------
  assign pe_own = {sci_on, sci_on};
  assign pe_per_out[pde_pkg::PE_TXD] = sci_txd_out;
  assign pe_per_oe[pde_pkg::PE_TXD] = 1'b1;
  assign pe_per_out[pde_pkg::PE_RXD] = 1'b0;
  assign pe_per_oe[pde_pkg::PE_RXD] = 1'b0;
  assign sci_rxd_in = sci_on ? pe_sync[pde_pkg::PE_RXD] : 1'b1;

  // ----------------------------------------------------------------
  // pin drive: owner picks direction, else the direction bit
  // ----------------------------------------------------------------
  // direction bits are bypassed on owned pins, so drive glitches
  // cannot come from software while a peripheral holds the pin
  assign pd_pin_oe = (pd_own & pd_per_oe) | (~pd_own & pd_dir_reg);
  assign pd_pin_out = (pd_own & pd_per_out) | (~pd_own & pd_lat_reg);
  assign pe_pin_oe = (pe_own & pe_per_oe) | (~pe_own & pe_dir_reg);
  assign pe_pin_out = (pe_own & pe_per_out) | (~pe_own & pe_lat_reg);
  // pullup follows the direction bit only, dropped on outputs
  assign pd_pullup_on = pd_pue_reg & ~pd_dir_reg;

  // ----------------------------------------------------------------
  // read mux: direction bit chooses latch or pin, even when owned
  // ----------------------------------------------------------------
  wire [6:0] pd_read = (pd_dir_reg & pd_lat_reg) | (~pd_dir_reg & pd_sync);
  wire [1:0] pe_read = (pe_dir_reg & pe_lat_reg) | (~pe_dir_reg & pe_sync);
  wire [7:0] route_read = {2'h0, tmr_on, spi_master_select, spi_module_enable, sci_on};

  // upper bits pad with zero on every port register
  always_comb
  begin
    rdata_next = 8'h00;
    if (hit_pd_data)
      rdata_next = {1'b0, pd_read};
    else if (hit_pd_dir)
      rdata_next = {1'b0, pd_dir_reg};
    else if (hit_pd_pue)
      rdata_next = {1'b0, pd_pue_reg};
    else if (hit_pe_data)
      rdata_next = {6'h00, pe_read};
    else if (hit_pe_dir)
      rdata_next = {6'h00, pe_dir_reg};
    else if (hit_route)
      rdata_next = route_read;
    else
      rdata_next = 8'h00; // unmapped reads zero
  end

  // ----------------------------------------------------------------
  // read data register: valid only in the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // data latches: written regardless of direction or ownership
  // ----------------------------------------------------------------
  // software should load these before raising direction bits
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pd_lat_reg <= pde_pkg::PD_LAT_RST;
      pe_lat_reg <= pde_pkg::PE_LAT_RST;
    end
    else
    begin
      if (reg_wr && hit_pd_data)
        pd_lat_reg <= reg_wdata[6:0];
      if (reg_wr && hit_pe_data)
        pe_lat_reg <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // direction and pullup registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pd_dir_reg <= pde_pkg::PD_DIR_RST;
      pe_dir_reg <= pde_pkg::PE_DIR_RST;
      pd_pue_reg <= pde_pkg::PD_PUE_RST;
    end
    else
    begin
      if (reg_wr && hit_pd_dir)
        pd_dir_reg <= reg_wdata[6:0];
      if (reg_wr && hit_pe_dir)
        pe_dir_reg <= reg_wdata[1:0];
      if (reg_wr && hit_pd_pue)
        pd_pue_reg <= reg_wdata[6:0];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_mosi_gpio: assert property (@(posedge clk_sys) disable iff (!nrst)
    !spi_module_enable |-> pd_pin_oe[2] == pd_dir_reg[2] && pd_pin_out[2] == pd_lat_reg[2])
    else $error("mosi pin not gpio with spi off");
  a_miso_spi: assert property (@(posedge clk_sys) disable iff (!nrst)
    spi_module_enable |-> pd_pin_oe[1] == spi_miso_oe)
    else $error("miso pin not spi driven");
  a_spi_readback: assert property (@(posedge clk_sys) disable iff (!nrst)
    reg_rd && hit_pd_data && pd_dir_reg[1] |=> reg_rdata[1] == $past(pd_lat_reg[1]))
    else $error("owned pin readback wrong");
  a_select_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    spi_module_enable && !spi_master_select |-> !pd_pin_oe[0])
    else $error("slave select driven");
  a_dir_reset: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(nrst) |-> pd_dir_reg == 7'h00)
    else $error("direction not cleared");
  a_pd_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    reg_wr && hit_pd_data |=> pd_lat_reg == $past(reg_wdata[6:0]))
    else $error("port d latch not written");
  a_pullup_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    (pd_pullup_on & pd_dir_reg) == 7'h00)
    else $error("pullup on output pin");
  a_txd_owned: assert property (@(posedge clk_sys) disable iff (!nrst)
    serial_iface_enable |-> pe_pin_oe[0] && pe_pin_out[0] == sci_txd_out)
    else $error("txd not driven by serial");
  a_pe_read: assert property (@(posedge clk_sys) disable iff (!nrst)
    reg_rd && hit_pe_data && !pe_dir_reg[0] |=> reg_rdata[0] == $past(pe_sync[0]))
    else $error("port e input read wrong");
  a_upper_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    reg_rd && hit_pe_dir |=> reg_rdata[7:2] == 6'h00)
    else $error("unused bits not zero");
  a_sck_spi: assert property (@(posedge clk_sys) disable iff (!nrst)
    spi_module_enable |-> pd_pin_oe[pde_pkg::PD_SCK] == spi_sck_oe
      && pd_pin_out[pde_pkg::PD_SCK] == spi_sck_out)
    else $error("sck pin not spi driven");
  a_sel_gpio: assert property (@(posedge clk_sys) disable iff (!nrst)
    !spi_module_enable || spi_master_select |->
      pd_pin_oe[pde_pkg::PD_SEL] == pd_dir_reg[pde_pkg::PD_SEL] && spi_select_in)
    else $error("select pin not gpio");
  a_pd_pin_read: assert property (@(posedge clk_sys) disable iff (!nrst)
    reg_rd && hit_pd_data && !pd_dir_reg[pde_pkg::PD_TMR0] |=>
      reg_rdata[pde_pkg::PD_TMR0] == $past(pd_sync[pde_pkg::PD_TMR0]))
    else $error("port d input read wrong");
  a_rxd_input: assert property (@(posedge clk_sys) disable iff (!nrst)
    serial_iface_enable |-> !pe_pin_oe[pde_pkg::PE_RXD]
      && sci_rxd_in == pe_sync[pde_pkg::PE_RXD])
    else $error("rxd pin not serial input");
  a_pe_gpio: assert property (@(posedge clk_sys) disable iff (!nrst)
    !serial_iface_enable |-> pe_pin_oe == pe_dir_reg && pe_pin_out == pe_lat_reg)
    else $error("port e not gpio with serial off");
  a_tmr_owned: assert property (@(posedge clk_sys) disable iff (!nrst)
    edge_level_select_high[0] || edge_level_select_low[0] |->
      pd_pin_oe[pde_pkg::PD_TMR0] == tmr_ch_oe[0])
    else $error("timer pin not timer driven");
endmodule

// >>> logic/pde_pkg.sv
package pde_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PD_DATA = 8'h03; // port d data latch
  localparam logic [7:0] ADDR_PE_DATA = 8'h08; // port e data latch
  localparam logic [7:0] ADDR_PD_DIR = 8'h07; // port d direction
  localparam logic [7:0] ADDR_PE_DIR = 8'h0c; // port e direction
  localparam logic [7:0] ADDR_PD_PUE = 8'h0d; // port d pullup enable
  localparam logic [7:0] ADDR_ROUTE = 8'h0e; // peripheral ownership controls
  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int PD_W = 7; // implemented port d pins
  localparam int PE_W = 2; // implemented port e pins
  localparam int TMR_CH = 3; // timer channels on port d
  localparam logic [6:0] PD_DIR_RST = 7'h00; // all inputs
  localparam logic [1:0] PE_DIR_RST = 2'h0; // all inputs
  localparam logic [6:0] PD_PUE_RST = 7'h00; // pullups off
  localparam logic [6:0] PD_LAT_RST = 7'h00; // latch value after reset
  localparam logic [1:0] PE_LAT_RST = 2'h0; // latch value after reset
  // ----------------------------------------------------------------
  // port d pin positions
  // ----------------------------------------------------------------
  localparam int PD_SEL = 0; // spi slave select
  localparam int PD_MISO = 1; // spi master in / slave out
  localparam int PD_MOSI = 2; // spi master out / slave in
  localparam int PD_SCK = 3; // spi serial clock
  localparam int PD_TMR0 = 4; // first timer channel pin
  // ----------------------------------------------------------------
  // port e pin positions
  // ----------------------------------------------------------------
  localparam int PE_TXD = 0; // serial transmit
  localparam int PE_RXD = 1; // serial receive
endpackage

// >>> logic/pde_sync.sv
`timescale 1ns/100ps
// three-stage synchroniser with second/third agreement filter
module pde_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // asynchronous input and its clean copy
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_reg; // metastability stage, read only by s2
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_next;

  // the output only moves once stages two and three agree
  assign out_next = (s2_reg & s3_reg) | (sync_out & (s2_reg | s3_reg));

  // ----------------------------------------------------------------
  // shift chain
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      sync_out <= out_next;
    end
  end
endmodule

// >>> tb/pde_pin_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// outside circuitry on the port d and port e pins
// ------------------------------------------------------------
module pde_pin_model (
  // clock
  input wire logic clk_sys,
  // what the device presents at its pads
  input wire logic [6:0] pd_pin_out,
  input wire logic [6:0] pd_pin_oe,
  input wire logic [6:0] pd_pullup_on,
  input wire logic [1:0] pe_pin_out,
  input wire logic [1:0] pe_pin_oe,
  // outside drive, bits 8:7 are port e
  input wire logic [8:0] ext_val,
  input wire logic [8:0] ext_en,
  // resolved pad levels
  output logic [6:0] pd_pin_in,
  output logic [1:0] pe_pin_in
);
  logic [8:0] float_pat; // undriven pads wander, never a settled guess
  logic [8:0] oe_all; // device drive enables
  logic [8:0] out_all; // device drive levels
  logic [8:0] pull_all; // internal pullups, port e has none
  logic [8:0] lvl; // resolved level
  initial float_pat = 9'h0aa;
  // toggle each cycle so a floating read never passes by luck
  always @(posedge clk_sys)
  begin
    float_pat <= ~float_pat;
  end
  assign oe_all = {pe_pin_oe, pd_pin_oe};
  assign out_all = {pe_pin_out, pd_pin_out};
  assign pull_all = {2'h0, pd_pullup_on};
  // device drive wins, then outside drive, then pullup, else wander
  assign lvl = (oe_all & out_all) | (~oe_all & ext_en & ext_val)
    | (~oe_all & ~ext_en & (pull_all | float_pat));
  assign pd_pin_in = lvl[6:0];
  assign pe_pin_in = lvl[8:7];
endmodule

// >>> tb/testbench.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// register port and pin ownership checks
// ------------------------------------------------------------
module testbench;
  logic clk_sys = 1'b0; // 50 mhz system clock
  logic nrst = 1'b0; // async reset, low active
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic spi_module_enable = 1'b0, spi_master_select = 1'b0;
  logic spi_mosi_out = 1'b0, spi_mosi_oe = 1'b0, spi_miso_out = 1'b0;
  logic spi_miso_oe = 1'b0, spi_sck_out = 1'b0, spi_sck_oe = 1'b0;
  logic spi_mosi_in, spi_miso_in, spi_sck_in, spi_select_in;
  logic [2:0] edge_level_select_high = 3'h0, edge_level_select_low = 3'h0;
  logic [2:0] tmr_ch_out = 3'h0, tmr_ch_oe = 3'h0, tmr_ch_in;
  logic serial_iface_enable = 1'b0, sci_txd_out = 1'b0, sci_rxd_in;
  logic [6:0] pd_pin_in, pd_pin_out, pd_pin_oe, pd_pullup_on;
  logic [1:0] pe_pin_in, pe_pin_out, pe_pin_oe;
  logic [8:0] ext_val = 9'h12a, ext_en = 9'h1ff; // outside drive
  int failures = 0;
  int samples_checked = 0;
  always #10 clk_sys = ~clk_sys;
  // ------------------------------------------------------------
  // device and outside circuitry
  // ------------------------------------------------------------
  pde_port_ctrl DUT (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .spi_module_enable(spi_module_enable), .spi_master_select(spi_master_select),
    .spi_mosi_out(spi_mosi_out), .spi_mosi_oe(spi_mosi_oe), .spi_miso_out(spi_miso_out),
    .spi_miso_oe(spi_miso_oe), .spi_sck_out(spi_sck_out), .spi_sck_oe(spi_sck_oe),
    .spi_mosi_in(spi_mosi_in), .spi_miso_in(spi_miso_in), .spi_sck_in(spi_sck_in),
    .spi_select_in(spi_select_in), .edge_level_select_high(edge_level_select_high),
    .edge_level_select_low(edge_level_select_low), .tmr_ch_out(tmr_ch_out),
    .tmr_ch_oe(tmr_ch_oe), .tmr_ch_in(tmr_ch_in), .serial_iface_enable(serial_iface_enable),
    .sci_txd_out(sci_txd_out), .sci_rxd_in(sci_rxd_in), .pd_pin_in(pd_pin_in),
    .pd_pin_out(pd_pin_out), .pd_pin_oe(pd_pin_oe), .pd_pullup_on(pd_pullup_on),
    .pe_pin_in(pe_pin_in), .pe_pin_out(pe_pin_out), .pe_pin_oe(pe_pin_oe));
  pde_pin_model pins (.clk_sys(clk_sys), .pd_pin_out(pd_pin_out), .pd_pin_oe(pd_pin_oe),
    .pd_pullup_on(pd_pullup_on), .pe_pin_out(pe_pin_out), .pe_pin_oe(pe_pin_oe),
    .ext_val(ext_val), .ext_en(ext_en), .pd_pin_in(pd_pin_in), .pe_pin_in(pe_pin_in));
  // ------------------------------------------------------------
  // bus tasks and comparison
  // ------------------------------------------------------------
  // one byte comparison, narrower results are zero extended
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
      failures++;
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // let the written register settle before any pad is looked at
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // pad changes need four edges through the synchroniser
  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic close_out();
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog, far beyond the hundred or so cycles the tests take
  initial
  begin
    #400000;
    failures++;
    close_out();
  end
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    settle();
    // reset state: all inputs, no pullups
    chk({1'b0, pd_pin_oe}, 8'h00);
    chk({6'h0, pe_pin_oe}, 8'h00);
    chk({1'b0, pd_pullup_on}, 8'h00);
    rd_chk(pde_pkg::ADDR_PD_DIR, 8'h00);
    rd_chk(pde_pkg::ADDR_PE_DIR, 8'h00);
    rd_chk(pde_pkg::ADDR_PD_DATA, 8'h2a);
    rd_chk(pde_pkg::ADDR_PE_DATA, 8'h02);
    // unmapped place ignores writes and reads zero
    wr(8'h3f, 8'hff);
    rd_chk(8'h3f, 8'h00);
    // latch loaded first, then outputs turned on
    wr(pde_pkg::ADDR_PD_DATA, 8'h55);
    rd_chk(pde_pkg::ADDR_PD_DATA, 8'h2a);
    wr(pde_pkg::ADDR_PD_DIR, 8'hff);
    rd_chk(pde_pkg::ADDR_PD_DIR, 8'h7f);
    chk({1'b0, pd_pin_oe}, 8'h7f);
    chk({1'b0, pd_pin_out}, 8'h55);
    rd_chk(pde_pkg::ADDR_PD_DATA, 8'h55);
    // mixed directions with pullups, outside released
    wr(pde_pkg::ADDR_PD_DIR, 8'h0f);
    wr(pde_pkg::ADDR_PD_PUE, 8'hff);
    ext_en <= 9'h180;
    settle();
    chk({1'b0, pd_pullup_on}, 8'h70);
    rd_chk(pde_pkg::ADDR_PD_DATA, 8'h75);
    rd_chk(pde_pkg::ADDR_PD_PUE, 8'h7f);
    ext_en <= 9'h1ff;
    // spi master owns d1 to d3 whatever the direction bits say
    wr(pde_pkg::ADDR_PD_DIR, 8'h00);
    spi_module_enable <= 1'b1;
    spi_master_select <= 1'b1;
    {spi_mosi_oe, spi_miso_oe, spi_sck_oe} <= 3'b111;
    {spi_mosi_out, spi_miso_out, spi_sck_out} <= 3'b101;
    settle();
    chk({1'b0, pd_pin_oe}, 8'h0e);
    chk({1'b0, pd_pin_out}, 8'h5d);
    {spi_mosi_oe, spi_miso_oe, spi_sck_oe} <= 3'b000;
    wr(pde_pkg::ADDR_PD_DIR, 8'h7f);
    chk({1'b0, pd_pin_oe}, 8'h71);
    chk({7'h0, spi_select_in}, 8'h01);
    rd_chk(pde_pkg::ADDR_PD_DATA, 8'h55);
    // slave mode hands d0 to the select input
    spi_master_select <= 1'b0;
    settle();
    chk({1'b0, pd_pin_oe}, 8'h70);
    chk({7'h0, spi_select_in}, 8'h00);
    chk({5'h0, spi_sck_in, spi_mosi_in, spi_miso_in}, 8'h05);
    spi_module_enable <= 1'b0;
    settle();
    chk({1'b0, pd_pin_oe}, 8'h7f);
    chk({7'h0, spi_select_in}, 8'h01);
    // timer channels take d4 and d6
    wr(pde_pkg::ADDR_PD_DIR, 8'h00);
    edge_level_select_high <= 3'b001;
    edge_level_select_low <= 3'b100;
    tmr_ch_oe <= 3'b111;
    tmr_ch_out <= 3'b100;
    settle();
    chk({1'b0, pd_pin_oe}, 8'h50);
    chk({1'b0, pd_pin_out}, 8'h45);
    chk({5'h0, tmr_ch_in}, 8'h06);
    rd_chk(pde_pkg::ADDR_ROUTE, 8'h28);
    edge_level_select_high <= 3'b000;
    edge_level_select_low <= 3'b000;
    // port e readback per direction bit
    wr(pde_pkg::ADDR_PE_DATA, 8'h01);
    rd_chk(pde_pkg::ADDR_PE_DATA, 8'h02);
    wr(pde_pkg::ADDR_PE_DIR, 8'h02);
    chk({6'h0, pe_pin_oe}, 8'h02);
    chk({6'h0, pe_pin_out}, 8'h01);
    settle();
    rd_chk(pde_pkg::ADDR_PE_DATA, 8'h00);
    // serial interface owns both port e pads
    serial_iface_enable <= 1'b1;
    sci_txd_out <= 1'b1;
    ext_val <= 9'h02a;
    settle();
    chk({6'h0, pe_pin_oe}, 8'h01);
    chk({6'h0, pe_pin_out[0], sci_rxd_in}, 8'h02);
    rd_chk(pde_pkg::ADDR_PE_DATA, 8'h01);
    rd_chk(pde_pkg::ADDR_ROUTE, 8'h01);
    serial_iface_enable <= 1'b0;
    settle();
    chk({6'h0, pe_pin_oe}, 8'h02);
    chk({7'h0, sci_rxd_in}, 8'h01);
    close_out();
  end
endmodule
